// file: design/sppc_settle_timer.v
`default_nettype none
`include "sppc_defines.vh"

// one-shot settle timer: start loads the count, done pulses at zero
module sppc_settle_timer #(
    parameter CNT_W  = `SPPC_CNT_W,
    parameter CYCLES = 125
) (
    input  wire             ref_clk_i,
    input  wire             rstn_i,
    input  wire             start_i,
    output reg              busy_o,
    output reg              done_o
);
    reg [CNT_W-1:0] cnt_q;   // cycles left

    // count down, pulse done once when the count runs out
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= {CNT_W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q  <= CYCLES[CNT_W-1:0];
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// file: design/sppc_top.v
// How it works
// - standby on fabric toggle or external instruction
// - standby keeps config, logic and I/O powered
// - bandgap, por, oscillator, pll and gated input buffers have standby-off options; bank buffers always drop in standby
// - bandgap off also drops analog, 1.2V only
// - por off in standby, detector stays
// - oscillator: static disable plus standby off
// - pll waits for low outputs, then off
// - per-bank referenced/differential buffer disable
// - per primary clock net dynamic enable
// - input buffer gating, clock inputs in standby
// - download starts when both supplies good
// - i/o tristated until configuration completes
// - regulated variant also watches external supply
// - user-mode monitor resets on core drop
// - bandgap off: low power por only
// - timer wake interrupt ends standby
`default_nettype none
`include "sppc_defines.vh"

module sppc_top #(
    parameter N_PLL       = 2,      // pll count
    parameter N_BANK      = 4,      // i/o bank count
    parameter N_PCLK      = 8,      // primary clock nets
    parameter N_IBUF      = 8,      // gated input buffers
    parameter LOW_VOLT    = 1'b1,   // 1.2 V core variant
    parameter HAS_REG     = 1'b0,   // internal regulator variant
    parameter SETTLE_CYC  =
        (`SPPC_SETTLE_NS * `SPPC_CLK_MHZ + 999) / 1000
) (
    input  wire                   ref_clk_i,
    input  wire                   rstn_i,
    // register port
    input  wire [`SPPC_ADDR_W-1:0] reg_addr_i,
    input  wire [31:0]            reg_wdata_i,
    input  wire                   reg_wr_i,
    input  wire                   reg_rd_i,
    output reg  [31:0]            reg_rdata_o,
    // standby requests
    input  wire                   stby_toggle_i,
    input  wire                   ext_stby_cmd_i,
    input  wire                   timer_wake_i,
    // supply monitors
    input  wire                   core_up_i,
    input  wire                   io_up_i,
    input  wire                   ext_up_i,
    input  wire                   core_dn_bg_i,
    input  wire                   core_dn_lp_i,
    input  wire                   cfg_done_i,
    input  wire [N_PLL-1:0]       pll_clk_low_i,
    // power controls
    output reg                    bg_en_o,
    output reg                    por_en_o,
    output reg                    lp_por_en_o,
    output reg                    osc_en_o,
    output reg  [N_PLL-1:0]       pll_en_o,
    output reg  [N_BANK-1:0]      bank_ref_en_o,
    output reg  [N_PCLK-1:0]      pclk_en_o,
    output reg  [N_IBUF-1:0]      ibuf_en_o,
    output reg                    cfg_start_o,
    output reg                    io_tristate_o,
    output reg                    por_rst_o,
    output reg                    standby_o
);
    // sequencer states
    localparam [2:0] ST_POR   = 3'h0;   // waiting for supplies
    localparam [2:0] ST_CFG   = 3'h1;   // download running
    localparam [2:0] ST_USER  = 3'h2;   // user mode
    localparam [2:0] ST_PLLW  = 3'h3;   // waiting for pll outputs low
    localparam [2:0] ST_STBY  = 3'h4;   // standby
    localparam [2:0] ST_WBG   = 3'h5;   // wake: analog core back first
    localparam [2:0] ST_WREST = 3'h6;   // wake: rest of subsystems

    reg [2:0]             st_q;
    reg [2:0]             st_d;
    reg [2:0]             ctrl_q;        // mon_en, bg_user_off, sleep
    reg [`SPPC_OPT_W-1:0] opt_q;         // standby options
    reg [N_PLL-1:0]       pll_stat_q;    // static pll disable
    reg [N_BANK-1:0]      bank_off_q;    // per-bank buffer off
    reg [N_PCLK-1:0]      clk_en_q;      // primary clock enables
    reg [N_IBUF-1:0]      pg_off_q;      // input buffer gating
    reg                   tog_q;         // last standby input level
    reg                   cmd_q;         // last external command level
    reg                   trip_q;        // sticky supply drop seen
    reg                   st_start;      // start settle timer
    wire                  settle_busy;
    wire                  settle_done;

    // standby request: either edge of toggle, or external command edge
    wire tog_evt = stby_toggle_i ^ tog_q;
    wire cmd_evt = ext_stby_cmd_i & ~cmd_q;
    wire req_sb  = tog_evt | cmd_evt;

    // bandgap may drop only on the 1.2 V variant
    wire bg_opt  = opt_q[`SPPC_OPT_BG] & LOW_VOLT;
    wire bg_user = ctrl_q[`SPPC_CTRL_BG_USER] & LOW_VOLT;

    // supplies good: regulated variant also needs external supply
    wire sup_ok  = core_up_i & io_up_i & (ext_up_i | ~HAS_REG);

    // drop detect: accurate monitor while bandgap on, lp cell otherwise
    wire drop    = bg_en_o ? core_dn_bg_i : core_dn_lp_i;

    wire in_sb   = (st_q == ST_STBY) | (st_q == ST_PLLW);
    wire pll_all_low = &(pll_clk_low_i | ~pll_en_o);

    // settle timer used between bandgap return and the rest
    sppc_settle_timer #(
        .CNT_W  (`SPPC_CNT_W),
        .CYCLES (SETTLE_CYC)
    ) u_settle (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .start_i   (st_start),
        .busy_o    (settle_busy),
        .done_o    (settle_done)
    );

    // next state
    always @* begin
        st_d     = st_q;
        st_start = 1'b0;
        case (st_q)
            ST_POR: begin
                if (sup_ok)
                    st_d = ST_CFG;
            end
            ST_CFG: begin
                if (!sup_ok)
                    st_d = ST_POR;
                else if (cfg_done_i)
                    st_d = ST_USER;
            end
            ST_USER: begin
                if (req_sb) begin
                    // pll must drain first if standby turns it off
                    if (opt_q[`SPPC_OPT_PLL] | bg_opt)
                        st_d = ST_PLLW;
                    else
                        st_d = ST_STBY;
                end
            end
            ST_PLLW: begin
                if (pll_all_low)
                    st_d = ST_STBY;
            end
            ST_STBY: begin
                // timer wake or another request ends standby
                if (timer_wake_i | req_sb) begin
                    st_d     = ST_WBG;
                    st_start = 1'b1;
                end
            end
            ST_WBG: begin
                if (settle_done)
                    st_d = ST_WREST;
            end
            ST_WREST: begin
                st_d = ST_USER;
            end
            default: begin
                st_d = ST_POR;
            end
        endcase
        // monitored drop restarts power-up from any user state
        if (ctrl_q[`SPPC_CTRL_MON_EN] && st_q != ST_POR &&
            st_q != ST_CFG && drop)
            st_d = ST_POR;
    end

    // state, request edges and drop flag
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q   <= ST_POR;
            tog_q  <= 1'b0;
            cmd_q  <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            tog_q <= stby_toggle_i;
            cmd_q <= ext_stby_cmd_i;
            // set wins over a software clear in the same cycle
            if (st_d == ST_POR && st_q != ST_POR && st_q != ST_CFG)
                trip_q <= 1'b1;
            else if (reg_wr_i && reg_addr_i == `SPPC_REG_STATUS &&
                     reg_wdata_i[0])
                trip_q <= 1'b0;
        end
    end

    // register writes: steer options and dynamic enables
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q     <= `SPPC_CTRL_RST;
            opt_q      <= `SPPC_OPT_RST;
            pll_stat_q <= {N_PLL{1'b0}};
            bank_off_q <= {N_BANK{1'b0}};
            clk_en_q   <= {N_PCLK{1'b1}};
            pg_off_q   <= {N_IBUF{1'b0}};
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `SPPC_REG_CTRL:     ctrl_q     <= reg_wdata_i[2:0];
                `SPPC_REG_OPT:      opt_q      <=
                    reg_wdata_i[`SPPC_OPT_W-1:0];
                `SPPC_REG_PLL_STAT: pll_stat_q <= reg_wdata_i[N_PLL-1:0];
                `SPPC_REG_BANK_OFF: bank_off_q <=
                    reg_wdata_i[N_BANK-1:0];
                `SPPC_REG_CLK_EN:   clk_en_q   <=
                    reg_wdata_i[N_PCLK-1:0];
                `SPPC_REG_PG_OFF:   pg_off_q   <=
                    reg_wdata_i[N_IBUF-1:0];
                default: begin
                end
            endcase
        end
    end

    // subsystem off-conditions, evaluated from next state
    wire sb_d    = (st_d == ST_STBY) | (st_d == ST_WBG);
    wire pllw_d  = (st_d == ST_PLLW);
    wire run_d   = (st_d != ST_POR);
    wire bg_off  = (sb_d & bg_opt) | bg_user;
    wire an_off  = (sb_d & bg_opt & (st_d != ST_WBG)) | bg_user;

    // power control outputs, all registered
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bg_en_o       <= 1'b1;
            por_en_o      <= 1'b1;
            lp_por_en_o   <= 1'b1;
            osc_en_o      <= 1'b0;
            pll_en_o      <= {N_PLL{1'b0}};
            bank_ref_en_o <= {N_BANK{1'b0}};
            pclk_en_o     <= {N_PCLK{1'b0}};
            ibuf_en_o     <= {N_IBUF{1'b0}};
            cfg_start_o   <= 1'b0;
            io_tristate_o <= 1'b1;
            por_rst_o     <= 1'b1;
            standby_o     <= 1'b0;
        end else begin
            // bandgap returns first on wake; por returns in the same cycle
            bg_en_o     <= ~(bg_off & (st_d != ST_WBG));
            por_en_o    <= ~((bg_off & (st_d != ST_WBG)) |
                             (sb_d & (st_d != ST_WBG) &
                              opt_q[`SPPC_OPT_POR]));
            // the limited detector never turns off
            lp_por_en_o <= 1'b1;
            // oscillator: static off, standby off, lost with bandgap
            osc_en_o    <= run_d & ~opt_q[`SPPC_OPT_OSC_STAT] &
                           ~(sb_d & opt_q[`SPPC_OPT_OSC]) &
                           ~an_off;
            // pll standby-off only once in standby, after drain
            pll_en_o    <= {N_PLL{run_d & ~an_off &
                           ~(sb_d & opt_q[`SPPC_OPT_PLL])}} &
                           ~pll_stat_q &
                           ~{N_PLL{opt_q[`SPPC_OPT_PLL_STAT]}};
            bank_ref_en_o <= {N_BANK{run_d & ~an_off & ~sb_d}} &
                             ~bank_off_q;
            pclk_en_o   <= {N_PCLK{run_d & ~pllw_d}} & clk_en_q;
            // gated buffers drop in standby when the option is set, and in every state when it is clear
            ibuf_en_o   <= ~(pg_off_q & {N_IBUF{sb_d &
                           opt_q[`SPPC_OPT_PG]}}) &
                           ~(pg_off_q & ~{N_IBUF{opt_q[`SPPC_OPT_PG]}});
            cfg_start_o <= (st_q == ST_POR) & (st_d == ST_CFG);
            // user i/o stays driven in standby, tristate until config
            io_tristate_o <= (st_d == ST_POR) | (st_d == ST_CFG);
            por_rst_o   <= (st_d == ST_POR);
            standby_o   <= sb_d | pllw_d;
        end
    end

    // read data, one cycle after the strobe
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `SPPC_REG_CTRL:
                        reg_rdata_o[2:0] <= ctrl_q;
                    `SPPC_REG_OPT:
                        reg_rdata_o[`SPPC_OPT_W-1:0] <= opt_q;
                    `SPPC_REG_PLL_STAT:
                        reg_rdata_o[N_PLL-1:0] <= pll_stat_q;
                    `SPPC_REG_BANK_OFF:
                        reg_rdata_o[N_BANK-1:0] <= bank_off_q;
                    `SPPC_REG_CLK_EN:
                        reg_rdata_o[N_PCLK-1:0] <= clk_en_q;
                    `SPPC_REG_PG_OFF:
                        reg_rdata_o[N_IBUF-1:0] <= pg_off_q;
                    `SPPC_REG_STATUS:
                        reg_rdata_o[7:0] <= {settle_busy, in_sb, 1'b0,
                                             st_q, trip_q, sup_ok};
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/sppc_fabric_model.sv
`default_nettype none

// fabric side: standby requests plus the plls' output-low flags
module sppc_fabric_model #(
    parameter int N_PLL = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             slow_i,
    input  wire logic [N_PLL-1:0] pll_en_i,
    input  wire logic             standby_i,
    output var  logic [N_PLL-1:0] pll_clk_low_o,
    output var  logic             stby_toggle_o = 1'b0,
    output var  logic             ext_stby_cmd_o = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    int drain_q; // cycles since the stop request

    // any level change of the toggle line asks for standby
    task automatic toggle();
        @(posedge ref_clk_i);
        stby_toggle_o <= ~stby_toggle_o;
    endtask

    // external master instruction, seen as a rising edge
    task automatic ext_cmd();
        @(posedge ref_clk_i);
        ext_stby_cmd_o <= 1'b1;
        @(posedge ref_clk_i);
        ext_stby_cmd_o <= 1'b0;
    endtask

    // enabled outputs read low only after the standby drain, so an early power-off shows up
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drain_q <= 0;
            pll_clk_low_o <= '1;
        end else begin
            drain_q <= standby_i ? drain_q + 1 : 0;
            pll_clk_low_o <= ~pll_en_i
                | {N_PLL{standby_i && drain_q >= (slow_i ? 6 : 0)}};
        end
    end
endmodule

`default_nettype wire

// file: dv/sppc_top_sva.sv
`default_nettype none

// port-level checker for the power sequencer
module sppc_top_sva #(
    parameter int N_PLL  = 2,
    parameter int N_BANK = 4
) (
    input wire logic              ref_clk_i,
    input wire logic              rstn_i,
    input wire logic              core_up_i,
    input wire logic              io_up_i,
    input wire logic              core_dn_bg_i,
    input wire logic              core_dn_lp_i,
    input wire logic              cfg_done_i,
    input wire logic [N_PLL-1:0]  pll_clk_low_i,
    input wire logic              bg_en_o,
    input wire logic              por_en_o,
    input wire logic              lp_por_en_o,
    input wire logic              osc_en_o,
    input wire logic [N_PLL-1:0]  pll_en_o,
    input wire logic [N_BANK-1:0] bank_ref_en_o,
    input wire logic              cfg_start_o,
    input wire logic              io_tristate_o,
    input wire logic              por_rst_o,
    input wire logic              standby_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_cfg_pulse: assert property (
        cfg_start_o |=> !cfg_start_o) else $error("cfg start too long");
    chk_cfg_supply: assert property (
        cfg_start_o |-> $past(core_up_i && io_up_i))
        else $error("cfg start without supplies");
    chk_tri_release: assert property (
        $fell(io_tristate_o) |-> $past(cfg_done_i))
        else $error("io released before config done");
    chk_reset_cause: assert property (
        $rose(por_rst_o) |-> $past(core_dn_bg_i || core_dn_lp_i
            || !(core_up_i && io_up_i))) else $error("reset without drop");
    // in standby, a pll may only lose power once its outputs sit low
    chk_pll_drain: assert property (
        standby_o && (($past(pll_en_o) & ~pll_en_o) != '0)
        |-> &($past(pll_clk_low_i) | ~$past(pll_en_o)))
        else $error("pll off while clocks run");
    chk_bg_analog: assert property (
        !bg_en_o |-> !por_en_o && !osc_en_o && pll_en_o == '0
            && bank_ref_en_o == '0) else $error("analog on without bg");
    chk_lp_por: assert property (
        !por_en_o |-> lp_por_en_o) else $error("no detector left");
    chk_wake_bg: assert property (
        $fell(standby_o) |-> bg_en_o && por_en_o)
        else $error("wake without bandgap");
    chk_wake_settle: assert property (
        $rose(bg_en_o) |-> (!osc_en_o) [*3])
        else $error("osc before settle");
endmodule

bind sppc_top sppc_top_sva #(.N_PLL(N_PLL), .N_BANK(N_BANK)) u_sva (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .core_up_i(core_up_i),
    .io_up_i(io_up_i), .core_dn_bg_i(core_dn_bg_i),
    .core_dn_lp_i(core_dn_lp_i), .cfg_done_i(cfg_done_i),
    .pll_clk_low_i(pll_clk_low_i), .bg_en_o(bg_en_o),
    .por_en_o(por_en_o), .lp_por_en_o(lp_por_en_o), .osc_en_o(osc_en_o),
    .pll_en_o(pll_en_o), .bank_ref_en_o(bank_ref_en_o),
    .cfg_start_o(cfg_start_o), .io_tristate_o(io_tristate_o),
    .por_rst_o(por_rst_o), .standby_o(standby_o)
);

`default_nettype wire

// file: dv/tb_top.sv
`default_nettype none
`include "sppc_defines.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic        wr;
        logic [3:0]  a;
        logic [31:0] d;
    } sppc_row_t;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [`SPPC_ADDR_W-1:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic stby_toggle_i, ext_stby_cmd_i, timer_wake_i = 1'b0;
    logic core_up_i = 1'b0, io_up_i = 1'b0, core_dn_bg_i = 1'b0;
    logic cfg_done_i = 1'b0, slow_i = 1'b0;
    logic [1:0] pll_clk_low_i, pll_en_o;
    logic bg_en_o, por_en_o, lp_por_en_o, osc_en_o, cfg_start_o;
    logic io_tristate_o, por_rst_o, standby_o;
    logic [3:0] bank_ref_en_o;
    logic [7:0] pclk_en_o, ibuf_en_o;
    logic [31:0] v;
    int err_total, total_checks, n_cfg, cycles;
    // reads show reset values, narrow fields and the unmapped hole
    sppc_row_t rows [16] = '{'{1'b0, 4'h0, 32'h1}, '{1'b0, 4'h1, 32'h0},
        '{1'b0, 4'h4, 32'hFF}, '{1'b1, 4'h3, 32'hF5}, '{1'b0, 4'h3, 32'h5},
        '{1'b1, 4'h9, 32'hFFFF}, '{1'b0, 4'h9, 32'h0},
        '{1'b1, 4'h2, 32'h7}, '{1'b0, 4'h2, 32'h3}, '{1'b1, 4'h2, 32'h0},
        '{1'b1, 4'h4, 32'h5A}, '{1'b0, 4'h4, 32'h5A},
        '{1'b1, 4'h5, 32'hF0F}, '{1'b0, 4'h5, 32'hF},
        '{1'b1, 4'h1, 32'hFF}, '{1'b0, 4'h1, 32'h7F}};

    sppc_top #(.SETTLE_CYC(4)) DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .stby_toggle_i(stby_toggle_i), .ext_stby_cmd_i(ext_stby_cmd_i),
        .timer_wake_i(timer_wake_i), .core_up_i(core_up_i),
        .io_up_i(io_up_i), .ext_up_i(1'b1), .core_dn_bg_i(core_dn_bg_i),
        .core_dn_lp_i(1'b0), .cfg_done_i(cfg_done_i),
        .pll_clk_low_i(pll_clk_low_i), .bg_en_o(bg_en_o),
        .por_en_o(por_en_o), .lp_por_en_o(lp_por_en_o),
        .osc_en_o(osc_en_o), .pll_en_o(pll_en_o),
        .bank_ref_en_o(bank_ref_en_o), .pclk_en_o(pclk_en_o),
        .ibuf_en_o(ibuf_en_o), .cfg_start_o(cfg_start_o),
        .io_tristate_o(io_tristate_o), .por_rst_o(por_rst_o),
        .standby_o(standby_o));

    sppc_fabric_model #(.N_PLL(2)) u_fab (.ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i), .slow_i(slow_i), .pll_en_i(pll_en_o),
        .standby_i(standby_o), .pll_clk_low_o(pll_clk_low_i),
        .stby_toggle_o(stby_toggle_i), .ext_stby_cmd_o(ext_stby_cmd_i));

    always #4 ref_clk_i = ~ref_clk_i;

    // cycle ceiling well above the 120 or so the run needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cfg_start_o === 1'b1) n_cfg++;
        if (cycles == 5000) begin
            err_total++;
            $display("mismatch timeout exp done got hang");
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 q = reg_rdata_o;
    endtask

    // raise the wake line on an edge, drop it once standby has ended
    task automatic wake();
        @(posedge ref_clk_i);
        timer_wake_i <= 1'b1;
        @(posedge ref_clk_i iff !standby_o);
        timer_wake_i <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk_i);
        chk("tri_rst", 1, io_tristate_o);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else begin
                rd(rows[i].a, v);
                chk("reg", rows[i].d, v);
            end
        end
        // power-up: core alone must not start the download
        core_up_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk("early_cfg", 0, n_cfg);
        io_up_i <= 1'b1;
        @(posedge ref_clk_i iff cfg_start_o);
        chk("tri_cfg", 1, io_tristate_o);
        cfg_done_i <= 1'b1;
        @(posedge ref_clk_i iff !io_tristate_o);
        #1 chk("pclk", 8'h5A, pclk_en_o);
        chk("bank", 4'hA, bank_ref_en_o);
        chk("osc_static", 0, osc_en_o);
        chk("pll_static", 0, pll_en_o);
        chk("ibuf_user", 8'hFF, ibuf_en_o);
        // standby by toggle, all standby-off options set, slow pll drain
        wr(4'h1, 32'h4F);
        slow_i <= 1'b1;
        u_fab.toggle();
        @(posedge ref_clk_i iff standby_o);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("drain", 2'b11, pll_en_o);
        @(posedge ref_clk_i iff !bg_en_o);
        #1 chk("osc_sb", 0, osc_en_o);
        chk("por_sb", 0, por_en_o);
        chk("lp_por", 1, lp_por_en_o);
        chk("ibuf_sb", 8'hF0, ibuf_en_o);
        chk("io_sb", 0, io_tristate_o);
        // bandgap returns first, oscillator still waits for the settle
        @(posedge ref_clk_i);
        timer_wake_i <= 1'b1;
        @(posedge ref_clk_i iff bg_en_o);
        #1 chk("bg_wake", 1, bg_en_o);
        chk("osc_wait", 0, osc_en_o);
        wake();
        @(posedge ref_clk_i iff osc_en_o);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("pll_wake", 2'b11, pll_en_o);
        // external instruction with no options: bandgap and oscillator stay up, gated buffers off
        wr(4'h1, 32'h0);
        slow_i <= 1'b0;
        u_fab.ext_cmd();
        @(posedge ref_clk_i iff standby_o);
        repeat (3) @(posedge ref_clk_i);
        #1 chk("bg_keep", 1, bg_en_o);
        chk("osc_keep", 1, osc_en_o);
        chk("ibuf_off", 8'hF0, ibuf_en_o);
        wake();
        repeat (8) @(posedge ref_clk_i);
        // core drop in user mode re-issues reset and sets trip
        core_dn_bg_i <= 1'b1;
        @(posedge ref_clk_i iff por_rst_o);
        core_dn_bg_i <= 1'b0;
        #1 chk("tri_drop", 1, io_tristate_o);
        rd(4'h6, v);
        chk("trip", 1, v[1]);
        wr(4'h6, 32'h1);
        rd(4'h6, v);
        chk("trip_clr", 0, v[1]);
        results();
    end
endmodule

`default_nettype wire

// file: include/sppc_defines.vh
`ifndef SPPC_DEFINES_VH
`define SPPC_DEFINES_VH

// register offsets (word index on the plain register port)
`define SPPC_ADDR_W        4
`define SPPC_REG_CTRL      4'h0
`define SPPC_REG_OPT       4'h1
`define SPPC_REG_PLL_STAT  4'h2
`define SPPC_REG_BANK_OFF  4'h3
`define SPPC_REG_CLK_EN    4'h4
`define SPPC_REG_PG_OFF    4'h5
`define SPPC_REG_STATUS    4'h6

// ctrl register fields
`define SPPC_CTRL_MON_EN   0
`define SPPC_CTRL_BG_USER  1
`define SPPC_CTRL_SLEEP    2

// standby option register fields
`define SPPC_OPT_BG        0
`define SPPC_OPT_POR       1
`define SPPC_OPT_OSC       2
`define SPPC_OPT_PLL       3
`define SPPC_OPT_OSC_STAT  4
`define SPPC_OPT_PLL_STAT  5
`define SPPC_OPT_PG        6
`define SPPC_OPT_W         7

// reset values
`define SPPC_CTRL_RST      3'h1
`define SPPC_OPT_RST       7'h00

// sequencing times
`define SPPC_CLK_MHZ       125
`define SPPC_SETTLE_NS     1000
`define SPPC_CNT_W         16

`endif
